// ===== tb/core_pipe_model.sv
// Pipeline and host model, one op per cycle.
// Assumes inputs change after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module core_pipe_model (
  // Operation request: 1 pc, 2 load, 3 store, 4 resource, 5 call, 6 host, 7 return
  input wire logic [2:0] op,
  input wire logic [7:0] thr,
  input wire logic [31:0] val,
  // Pipeline and debugger signals
  output logic pc_valid,
  output logic mem_valid,
  output logic mem_is_load,
  output logic res_valid,
  output logic call_valid,
  output logic host_debug_req,
  output logic debug_return,
  output logic [7:0] pc_thread,
  output logic [7:0] mem_thread,
  output logic [7:0] res_thread,
  output logic [7:0] call_thread,
  output logic [31:0] pc,
  output logic [31:0] mem_addr,
  output logic [31:0] res_id,
  output logic [31:0] ctx_pc,
  output logic [31:0] ctx_sp,
  output logic [31:0] ctx_status
);
  assign pc_valid = op == 3'h1;
  assign mem_valid = op == 3'h2 || op == 3'h3;
  assign mem_is_load = op == 3'h2;
  assign res_valid = op == 3'h4;
  assign call_valid = op == 3'h5;
  assign host_debug_req = op == 3'h6;
  assign debug_return = op == 3'h7;
  assign pc_thread = thr;
  assign mem_thread = thr;
  assign res_thread = thr;
  assign call_thread = thr;
  assign pc = val;
  assign mem_addr = val;
  assign res_id = val;
  // Context differs per field so swapped captures show
  assign ctx_pc = val;
  assign ctx_sp = ~val;
  assign ctx_status = {21'h00_0000, val[10:0]};
endmodule // core_pipe_model
`default_nettype wire

// ===== tb/debug_breakpoint_watch_unit_assertions.sv
// Debug unit checker.
// Assumes binding to the top; ports only.
`timescale 1ns/100ps
`default_nettype none
module debug_breakpoint_watch_unit_assertions
  import debug_unit_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register and scratch ports
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic cfg_scratch_write,
  input wire logic [2:0] cfg_scratch_index,
  input wire logic [31:0] cfg_scratch_rdata,
  // Debug requests and control
  input wire logic host_debug_req,
  input wire logic call_valid,
  input wire logic debug_return,
  input wire logic debug_entry,
  input wire logic in_debug,
  input wire logic [7:0] thread_halt,
  input wire logic [7:0] reg_read_thread,
  input wire logic [4:0] reg_read_register
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_entry_one_cycle: assert property (debug_entry |=> !debug_entry)
    else $error("entry too long");
  a_host_enters: assert property (host_debug_req && !in_debug |=> debug_entry && in_debug)
    else $error("host missed");
  a_call_enters: assert property (call_valid && !in_debug |=> debug_entry)
    else $error("call missed");
  a_halted_deaf: assert property (in_debug && !debug_return |=> !debug_entry)
    else $error("entry while halted");
  a_entry_halts: assert property (debug_entry |-> in_debug && thread_halt == 8'hFF)
    else $error("halt not full");
  a_halt_holds: assert property (in_debug && !debug_return |=> in_debug && thread_halt == 8'hFF)
    else $error("halt dropped");
  a_return_frees: assert property (in_debug && debug_return |=> !in_debug)
    else $error("return ignored");
  a_thread_operand: assert property (reg_write && reg_addr[9:2] == IDX_RR_THREAD
    |=> reg_read_thread == $past(reg_wdata[7:0])) else $error("thread operand");
  a_reg_operand: assert property (reg_write && reg_addr[9:2] == IDX_RR_REG
    |=> reg_read_register == $past(reg_wdata[4:0])) else $error("register operand");
  a_scratch_shared: assert property (reg_write && reg_addr[9:5] == 5'h04
    ##1 cfg_scratch_index == $past(reg_addr[4:2]) |-> cfg_scratch_rdata == $past(reg_wdata))
    else $error("scratch not shared");
  c_host: cover property (host_debug_req && !in_debug);
  c_return: cover property (in_debug && debug_return);
  c_cfg_write: cover property (cfg_scratch_write);
endmodule // debug_breakpoint_watch_unit_assertions
`default_nettype wire

// ===== tb/debug_breakpoint_watch_unit_tb.sv
// Debug unit bench with pipeline model.
// Assumes 20 MHz clock, async active-high reset.
`timescale 1ns/100ps
`default_nettype none
module debug_breakpoint_watch_unit_tb;
  typedef struct {logic [9:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  logic core_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, cfg_scratch_write = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [31:0] reg_wdata = 32'h0000_0000, cfg_scratch_wdata = 32'h0000_0000, val = 32'h0000_0000;
  logic [2:0] cfg_scratch_index = 3'h0, op = 3'h0;
  logic [7:0] thr = 8'h00, stopv = 8'h00;
  wire [31:0] reg_rdata, cfg_scratch_rdata, pc, mem_addr, res_id, ctx_pc, ctx_sp, ctx_status;
  wire [7:0] thread_halt, reg_read_thread, pc_thread, mem_thread, res_thread, call_thread;
  wire [4:0] reg_read_register;
  wire debug_entry, in_debug, pc_valid, mem_valid, mem_is_load, res_valid;
  wire call_valid, host_debug_req, debug_return;
  int bad_count = 0, n_compared = 0, cyc = 0;
  row_t rows[12] = '{'{10'h0C0, 32'h1234_5678, 32'h1234_5678}, '{10'h100, '1, 32'h00FF_0003},
    '{10'h1C0, '1, 32'h00FF_0007}, '{10'h270, '1, 32'h00FF_0003}, '{10'h04C, '1, 32'h0000_00FF},
    '{10'h050, '1, 32'h0000_001F}, '{10'h060, '1, 32'h0000_00FF}, '{10'h054, '1, 32'h0003_FF07},
    '{10'h040, '1, 32'h0000_06DF}, '{10'h09C, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{10'h204, 32'h0F0F_0F0F, 32'h0F0F_0F0F}, '{10'h3FC, '1, 32'h0000_0000}};

  debug_breakpoint_watch_unit dut (.*);
  core_pipe_model model (.*);

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      finish_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] w);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic ret;
    @(posedge core_clk);
    op <= 3'h7;
    @(posedge core_clk);
    op <= 3'h0;
    #1 chk("in_debug", in_debug, 32'h0000_0000);
    chk("thread_halt", thread_halt, stopv);
  endtask
  // One event; c is the cause word, 0 if none
  task automatic ev(input logic [2:0] o, input logic [7:0] t, input logic [31:0] v,
                    input logic [31:0] c);
    @(posedge core_clk);
    op <= o;
    thr <= t;
    val <= v;
    @(posedge core_clk);
    op <= 3'h0;
    #1 chk("in_debug", in_debug, c != 0);
    if (c != 0) begin
      chk("thread_halt", thread_halt, 32'h0000_00FF);
      rd(10'h054, c);
      if (c[2]) rd(10'h058, v);
      ret;
    end
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    do_reset;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    // Mid-run reset clears all
    do_reset;
    foreach (rows[i]) rd(rows[i].a, 32'h0000_0000);
    stopv = 8'h0A;
    wr(10'h060, 32'h0000_000A);
    // Host entry; a call while halted is dropped
    @(posedge core_clk);
    op <= 3'h6;
    thr <= 8'h33;
    val <= 32'h89AB_CDEF;
    @(posedge core_clk);
    op <= 3'h5;
    thr <= 8'h02;
    @(posedge core_clk);
    op <= 3'h0;
    rd(10'h054, 32'h0000_0001);
    rd(10'h044, 32'h89AB_CDEF);
    rd(10'h048, 32'h7654_3210);
    ret;
    ev(3'h5, 8'h05, 32'h0000_0000, 32'h0000_0502);
    wr(10'h0C4, 32'h0000_4000);
    wr(10'h0C8, 32'h0000_4000);
    wr(10'h104, 32'h0020_0001);
    wr(10'h108, 32'h0020_0001);
    ev(3'h1, 8'h04, 32'h0000_4000, 32'h0000_0000);
    ev(3'h1, 8'h05, 32'h0000_4000, 32'h0001_0503);
    wr(10'h104, 32'h0020_0003);
    ev(3'h1, 8'h05, 32'h0000_4004, 32'h0001_0503);
    wr(10'h104, 32'h0000_0000);
    wr(10'h108, 32'h0000_0000);
    wr(10'h148, 32'h0000_0100);
    wr(10'h188, 32'h0000_01FF);
    wr(10'h1C8, 32'h0001_0001);
    ev(3'h2, 8'h00, 32'h0000_0150, 32'h0000_0000);
    ev(3'h3, 8'h00, 32'h0000_0150, 32'h0002_0004);
    ev(3'h3, 8'h00, 32'h0000_0300, 32'h0000_0000);
    wr(10'h1C8, 32'h0001_0007);
    ev(3'h3, 8'h00, 32'h0000_0300, 32'h0002_0004);
    ev(3'h2, 8'h00, 32'h0000_0080, 32'h0002_0004);
    wr(10'h1C8, 32'h0000_0000);
    wr(10'h20C, 32'h0000_FF00);
    wr(10'h24C, 32'h0000_1200);
    wr(10'h27C, 32'h0080_0001);
    ev(3'h4, 8'h06, 32'h0000_12AB, 32'h0000_0000);
    ev(3'h4, 8'h07, 32'h0000_12AB, 32'h0003_0705);
    wr(10'h27C, 32'h0080_0003);
    ev(3'h4, 8'h07, 32'h0000_12AB, 32'h0000_0000);
    ev(3'h4, 8'h07, 32'h0000_3400, 32'h0003_0705);
    // Scratch via both ports
    cfg_scratch_index <= 3'h3;
    wr(10'h08C, 32'h0BAD_F00D);
    #1 chk("cfg_scratch_rdata", cfg_scratch_rdata, 32'h0BAD_F00D);
    @(posedge core_clk);
    cfg_scratch_write <= 1'b1;
    cfg_scratch_index <= 3'h2;
    cfg_scratch_wdata <= 32'h5EED_1234;
    @(posedge core_clk);
    cfg_scratch_write <= 1'b0;
    rd(10'h088, 32'h5EED_1234);
    finish_test;
  end
endmodule // debug_breakpoint_watch_unit_tb

bind debug_breakpoint_watch_unit debug_breakpoint_watch_unit_assertions checker_i (.*);
`default_nettype wire

// ===== verilog/debug_breakpoint_watch_unit.sv
// Debug unit top: registers, capture, cause, run control.
// Assumes events and context arrive in one cycle.
//
// Notes on behaviour
// RULE_01: Saved PC captured on entry, software-writable.
// RULE_02: Saved SP captured on entry, software-writable.
// RULE_03: Saved status captured on entry.
// RULE_04: 8-bit thread operand for register reads.
// RULE_05: 5-bit register operand for register reads.
// RULE_06: 3-bit cause code, reset 0: host, call, ibreak, dwatch, rwatch.
// RULE_07: 2-bit index of the firing unit, lowest wins, 0 for host/call.
// RULE_08: 8-bit thread causing entry; 0 for a host request.
// RULE_09: Event data: address on data hit, id on resource hit.
// RULE_10: After return, threads in the stop vector stay halted.
// RULE_11: Eight scratch words shared with the config port.
// RULE_12: Four 32-bit instruction breakpoints raising entry.
// RULE_13: Condition bit picks PC equal or PC not equal.
// RULE_14: Breakpoint needs enable and thread enable; resets to 0.
// RULE_15: Four data watchpoints with two address registers each.
// RULE_16: Data condition bit picks A and B, or A or B.
// RULE_17: Loads watched only with the load bit; resets to 0.
// RULE_18: Four resource watchpoints with mask and value registers.
// RULE_19: Resource condition bit picks condition A or condition B.
// RULE_20: Resource watchpoint needs enable and thread enable.
// RULE_21: Data A tests first address, B tests second address.
// RULE_22: Resource id masked, then compared with value.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module debug_breakpoint_watch_unit
  import debug_unit_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Tile configuration scratch port
  input wire logic cfg_scratch_write,
  input wire logic [2:0] cfg_scratch_index,
  input wire logic [31:0] cfg_scratch_wdata,
  output logic [31:0] cfg_scratch_rdata,
  // Debug requests
  input wire logic host_debug_req,
  input wire logic call_valid,
  input wire logic [7:0] call_thread,
  input wire logic debug_return,
  // Pipeline observation
  input wire logic pc_valid,
  input wire logic [7:0] pc_thread,
  input wire logic [31:0] pc,
  input wire logic mem_valid,
  input wire logic mem_is_load,
  input wire logic [7:0] mem_thread,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [7:0] res_thread,
  input wire logic [31:0] res_id,
  // Context of the entering thread
  input wire logic [31:0] ctx_pc,
  input wire logic [31:0] ctx_sp,
  input wire logic [31:0] ctx_status,
  // Debug control to the core
  output logic debug_entry,
  output logic in_debug,
  output logic [7:0] thread_halt,
  output logic [7:0] reg_read_thread,
  output logic [4:0] reg_read_register
);

  typedef enum logic {RUNNING, HALTED} dbg_state_t;

  dbg_state_t state_q;
  logic [31:0] status_q;
  logic [31:0] spc_q;
  logic [31:0] ssp_q;
  logic [31:0] rr_thread_q;
  logic [31:0] rr_reg_q;
  logic [31:0] cause_q;
  logic [31:0] event_data_q;
  logic [31:0] stop_q;
  logic [31:0] scratch_q [NUM_SCRATCH];
  logic [31:0] ib_addr_q [NUM_WATCH];
  logic [31:0] ib_ctrl_q [NUM_WATCH];
  logic [31:0] dw_addr1_q [NUM_WATCH];
  logic [31:0] dw_addr2_q [NUM_WATCH];
  logic [31:0] dw_ctrl_q [NUM_WATCH];
  logic [31:0] rw_mask_q [NUM_WATCH];
  logic [31:0] rw_value_q [NUM_WATCH];
  logic [31:0] rw_ctrl_q [NUM_WATCH];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic entry_q;
  logic [7:0] halt_q;
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;
  logic [7:0] idx;
  logic entry;
  logic [2:0] cause_code;
  logic [1:0] cause_index;
  logic [7:0] cause_thread;
  logic [31:0] cause_new;

  assign idx = reg_addr[9:2];

  // Only writable bits change
  function automatic logic [31:0] masked(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] wmask);
    masked = (old & ~wmask) | (wd & wmask);
  endfunction

  // Four registers from base
  function automatic logic in_group(input logic [7:0] a, input logic [7:0] base);
    in_group = a[7:2] == base[7:2];
  endfunction

  instr_break_match #(
    .NUM(NUM_WATCH)
  ) u_ib (
    .pc_valid(pc_valid),
    .pc_thread(pc_thread),
    .pc(pc),
    .break_addr(ib_addr_q),
    .break_ctrl(ib_ctrl_q),
    .hit(ib_hit)
  );

  watch_match #(
    .NUM(NUM_WATCH)
  ) u_watch (
    .mem_valid(mem_valid),
    .mem_is_load(mem_is_load),
    .mem_thread(mem_thread),
    .mem_addr(mem_addr),
    .res_valid(res_valid),
    .res_thread(res_thread),
    .res_id(res_id),
    .dw_addr1(dw_addr1_q),
    .dw_addr2(dw_addr2_q),
    .dw_ctrl(dw_ctrl_q),
    .rw_mask(rw_mask_q),
    .rw_value(rw_value_q),
    .rw_ctrl(rw_ctrl_q),
    .data_hit(dw_hit),
    .res_hit(rw_hit)
  );

  // Lower cause code wins on coincidence
  always_comb begin
    cause_code = CAUSE_NONE;
    cause_index = 2'h0;
    cause_thread = 8'h00;
    if (host_debug_req) begin
      cause_code = CAUSE_HOST; // RULE_06
      cause_thread = 8'h00; // RULE_08
    end else if (call_valid) begin
      cause_code = CAUSE_CALL; // RULE_06
      cause_thread = call_thread; // RULE_08
    end else if (|ib_hit) begin
      cause_code = CAUSE_IBREAK;
      cause_index = lowest_index(ib_hit); // RULE_07
      cause_thread = pc_thread;
    end else if (|dw_hit) begin
      cause_code = CAUSE_DWATCH;
      cause_index = lowest_index(dw_hit); // RULE_07
      cause_thread = mem_thread;
    end else if (|rw_hit) begin
      cause_code = CAUSE_RWATCH;
      cause_index = lowest_index(rw_hit); // RULE_07
      cause_thread = res_thread;
    end
  end

  // Events while halted are dropped
  assign entry = (state_q == RUNNING) && (cause_code != CAUSE_NONE);

  always_comb begin
    cause_new = CAUSE_RESET;
    cause_new[CAUSE_CODE_LSB +: 3] = cause_code;
    cause_new[CAUSE_THREAD_LSB +: 8] = cause_thread;
    cause_new[CAUSE_INDEX_LSB +: 2] = cause_index;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= RUNNING;
    end else begin
      case (state_q)
        RUNNING: begin
          if (entry) begin
            state_q <= HALTED;
          end
        end
        HALTED: begin
          if (debug_return) begin
            state_q <= RUNNING;
          end
        end
        default: begin
          state_q <= RUNNING;
        end
      endcase
    end
  end

  // Entry wins over a same-cycle write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_q <= WORD_RESET;
      spc_q <= WORD_RESET;
      ssp_q <= WORD_RESET;
    end else if (entry) begin
      status_q <= ctx_status & STATUS_CAPMASK; // RULE_03
      spc_q <= ctx_pc; // RULE_01
      ssp_q <= ctx_sp; // RULE_02
    end else if (reg_write) begin
      if (idx == IDX_SAVED_STATUS) begin
        status_q <= masked(status_q, reg_wdata, STATUS_WMASK);
      end
      if (idx == IDX_SAVED_PC) begin
        spc_q <= reg_wdata; // RULE_01
      end
      if (idx == IDX_SAVED_SP) begin
        ssp_q <= reg_wdata; // RULE_02
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cause_q <= CAUSE_RESET;
      event_data_q <= WORD_RESET;
    end else if (entry) begin
      cause_q <= cause_new; // RULE_06 RULE_07 RULE_08
      if (cause_code == CAUSE_DWATCH) begin
        event_data_q <= mem_addr; // RULE_09
      end else if (cause_code == CAUSE_RWATCH) begin
        event_data_q <= res_id; // RULE_09
      end
    end else if (reg_write) begin
      if (idx == IDX_CAUSE) begin
        cause_q <= masked(cause_q, reg_wdata, CAUSE_WMASK);
      end
      if (idx == IDX_EVENT_DATA) begin
        event_data_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rr_thread_q <= WORD_RESET;
      rr_reg_q <= WORD_RESET;
      stop_q <= WORD_RESET;
    end else if (reg_write) begin
      if (idx == IDX_RR_THREAD) begin
        rr_thread_q <= masked(rr_thread_q, reg_wdata, RR_THREAD_WMASK); // RULE_04
      end
      if (idx == IDX_RR_REG) begin
        rr_reg_q <= masked(rr_reg_q, reg_wdata, RR_REG_WMASK); // RULE_05
      end
      if (idx == IDX_STOP_VEC) begin
        stop_q <= masked(stop_q, reg_wdata, STOP_WMASK);
      end
    end
  end

  // Register port wins a clash
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SCRATCH; i++) begin
        scratch_q[i] <= WORD_RESET;
      end
    end else if (reg_write && idx[7:3] == IDX_SCRATCH[7:3]) begin
      scratch_q[idx[2:0]] <= reg_wdata; // RULE_11
    end else if (cfg_scratch_write) begin
      scratch_q[cfg_scratch_index] <= cfg_scratch_wdata; // RULE_11
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_WATCH; i++) begin
        ib_addr_q[i] <= WORD_RESET;
        ib_ctrl_q[i] <= CTRL_RESET; // RULE_14
        dw_addr1_q[i] <= WORD_RESET;
        dw_addr2_q[i] <= WORD_RESET;
        dw_ctrl_q[i] <= CTRL_RESET; // RULE_17
        rw_mask_q[i] <= WORD_RESET;
        rw_value_q[i] <= WORD_RESET;
        rw_ctrl_q[i] <= CTRL_RESET;
      end
    end else if (reg_write) begin
      if (in_group(idx, IDX_IB_ADDR)) begin
        ib_addr_q[idx[1:0]] <= reg_wdata; // RULE_12
      end
      if (in_group(idx, IDX_IB_CTRL)) begin
        ib_ctrl_q[idx[1:0]] <= masked(ib_ctrl_q[idx[1:0]], reg_wdata, IB_CTRL_WMASK);
      end
      if (in_group(idx, IDX_DW_ADDR1)) begin
        dw_addr1_q[idx[1:0]] <= reg_wdata; // RULE_15
      end
      if (in_group(idx, IDX_DW_ADDR2)) begin
        dw_addr2_q[idx[1:0]] <= reg_wdata; // RULE_15
      end
      if (in_group(idx, IDX_DW_CTRL)) begin
        dw_ctrl_q[idx[1:0]] <= masked(dw_ctrl_q[idx[1:0]], reg_wdata, DW_CTRL_WMASK);
      end
      if (in_group(idx, IDX_RW_MASK)) begin
        rw_mask_q[idx[1:0]] <= reg_wdata; // RULE_18
      end
      if (in_group(idx, IDX_RW_VALUE)) begin
        rw_value_q[idx[1:0]] <= reg_wdata; // RULE_18
      end
      if (in_group(idx, IDX_RW_CTRL)) begin
        rw_ctrl_q[idx[1:0]] <= masked(rw_ctrl_q[idx[1:0]], reg_wdata, RW_CTRL_WMASK);
      end
    end
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    rdata_d = WORD_RESET;
    if (idx[7:3] == IDX_SCRATCH[7:3]) begin
      rdata_d = scratch_q[idx[2:0]];
    end else if (in_group(idx, IDX_IB_ADDR)) begin
      rdata_d = ib_addr_q[idx[1:0]];
    end else if (in_group(idx, IDX_IB_CTRL)) begin
      rdata_d = ib_ctrl_q[idx[1:0]];
    end else if (in_group(idx, IDX_DW_ADDR1)) begin
      rdata_d = dw_addr1_q[idx[1:0]];
    end else if (in_group(idx, IDX_DW_ADDR2)) begin
      rdata_d = dw_addr2_q[idx[1:0]];
    end else if (in_group(idx, IDX_DW_CTRL)) begin
      rdata_d = dw_ctrl_q[idx[1:0]];
    end else if (in_group(idx, IDX_RW_MASK)) begin
      rdata_d = rw_mask_q[idx[1:0]];
    end else if (in_group(idx, IDX_RW_VALUE)) begin
      rdata_d = rw_value_q[idx[1:0]];
    end else if (in_group(idx, IDX_RW_CTRL)) begin
      rdata_d = rw_ctrl_q[idx[1:0]];
    end else begin
      case (idx)
        IDX_SAVED_STATUS: rdata_d = status_q;
        IDX_SAVED_PC: rdata_d = spc_q;
        IDX_SAVED_SP: rdata_d = ssp_q;
        IDX_RR_THREAD: rdata_d = rr_thread_q;
        IDX_RR_REG: rdata_d = rr_reg_q;
        IDX_CAUSE: rdata_d = cause_q;
        IDX_EVENT_DATA: rdata_d = event_data_q;
        IDX_STOP_VEC: rdata_d = stop_q;
        default: rdata_d = WORD_RESET;
      endcase
    end
  end

  // Read data stands one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= WORD_RESET;
    end else if (reg_read) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= WORD_RESET;
    end
  end

  // All held while halted, then the stop vector
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      entry_q <= 1'b0;
      halt_q <= 8'h00;
    end else begin
      entry_q <= entry;
      if (entry || (state_q == HALTED && !debug_return)) begin
        halt_q <= 8'hFF;
      end else begin
        halt_q <= stop_q[7:0]; // RULE_10
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign cfg_scratch_rdata = scratch_q[cfg_scratch_index];
  assign debug_entry = entry_q;
  assign in_debug = (state_q == HALTED);
  assign thread_halt = halt_q;
  assign reg_read_thread = rr_thread_q[7:0]; // RULE_04
  assign reg_read_register = rr_reg_q[4:0]; // RULE_05

endmodule // debug_breakpoint_watch_unit
`default_nettype wire

// ===== verilog/debug_unit_pkg.sv
// Debug unit constants and helpers.
// Assumes index = byte address / 4.
package debug_unit_pkg;

  // Register indices
  localparam logic [7:0] IDX_SAVED_STATUS = 8'h10;
  localparam logic [7:0] IDX_SAVED_PC = 8'h11;
  localparam logic [7:0] IDX_SAVED_SP = 8'h12;
  localparam logic [7:0] IDX_RR_THREAD = 8'h13;
  localparam logic [7:0] IDX_RR_REG = 8'h14;
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_EVENT_DATA = 8'h16;
  localparam logic [7:0] IDX_STOP_VEC = 8'h18;
  localparam logic [7:0] IDX_SCRATCH = 8'h20;
  localparam logic [7:0] IDX_IB_ADDR = 8'h30;
  localparam logic [7:0] IDX_IB_CTRL = 8'h40;
  localparam logic [7:0] IDX_DW_ADDR1 = 8'h50;
  localparam logic [7:0] IDX_DW_ADDR2 = 8'h60;
  localparam logic [7:0] IDX_DW_CTRL = 8'h70;
  localparam logic [7:0] IDX_RW_MASK = 8'h80;
  localparam logic [7:0] IDX_RW_VALUE = 8'h90;
  localparam logic [7:0] IDX_RW_CTRL = 8'h9C;

  localparam int NUM_THREADS = 8;
  localparam int NUM_SCRATCH = 8;
  localparam int NUM_WATCH = 4;

  // Control register fields
  localparam int WATCH_ENABLE_BIT = 0;
  localparam int AND_OR_SELECT_BIT = 1;
  localparam int TRIGGER_ON_LOAD_BIT = 2;
  localparam int THREAD_EN_LSB = 16;

  // Cause register fields
  localparam int CAUSE_CODE_LSB = 0;
  localparam int CAUSE_THREAD_LSB = 8;
  localparam int CAUSE_INDEX_LSB = 16;

  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_CALL = 3'h2;
  localparam logic [2:0] CAUSE_IBREAK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;

  // Writable bits of each register, and the status bits captured on entry
  localparam logic [31:0] STATUS_WMASK = 32'h0000_06DF;
  localparam logic [31:0] STATUS_CAPMASK = 32'h0000_07DF;
  localparam logic [31:0] RR_THREAD_WMASK = 32'h0000_00FF;
  localparam logic [31:0] RR_REG_WMASK = 32'h0000_001F;
  localparam logic [31:0] CAUSE_WMASK = 32'h0003_FF07;
  localparam logic [31:0] STOP_WMASK = 32'h0000_00FF;
  localparam logic [31:0] IB_CTRL_WMASK = 32'h00FF_0003;
  localparam logic [31:0] DW_CTRL_WMASK = 32'h00FF_0007;
  localparam logic [31:0] RW_CTRL_WMASK = 32'h00FF_0003;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;

  // Watch unit armed for this thread
  function automatic logic thread_enabled(input logic [31:0] ctrl, input logic [7:0] thread);
    thread_enabled = ctrl[WATCH_ENABLE_BIT] && (thread < 8'(NUM_THREADS))
                     && ctrl[THREAD_EN_LSB + int'(thread[2:0])];
  endfunction

  // Lowest set index of a four-bit hit vector
  function automatic logic [1:0] lowest_index(input logic [3:0] hit);
    lowest_index = hit[0] ? 2'h0 : hit[1] ? 2'h1 : hit[2] ? 2'h2 : 2'h3;
  endfunction

endpackage

// ===== verilog/instr_break_match.sv
// Instruction breakpoint comparators.
// Assumes pc inputs valid with pc_valid.
`timescale 1ns/100ps
`default_nettype none
module instr_break_match
  import debug_unit_pkg::*;
#(
  parameter int NUM = NUM_WATCH
) (
  // Executing instruction
  input wire logic pc_valid,
  input wire logic [7:0] pc_thread,
  input wire logic [31:0] pc,
  // Breakpoint settings
  input wire logic [31:0] break_addr [NUM],
  input wire logic [31:0] break_ctrl [NUM],
  // Result
  output logic [NUM-1:0] hit
);

  initial begin
    if (NUM < 1 || NUM > NUM_WATCH) $error("instr_break_match: NUM out of range");
  end

  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      hit[i] = pc_valid && thread_enabled(break_ctrl[i], pc_thread) // RULE_14
               && ((pc == break_addr[i]) != break_ctrl[i][AND_OR_SELECT_BIT]); // RULE_12 RULE_13
    end
  end

endmodule // instr_break_match
`default_nettype wire

// ===== verilog/watch_match.sv
// Data and resource watchpoint comparators.
// Assumes reports valid with their valid bit.
`timescale 1ns/100ps
`default_nettype none
module watch_match
  import debug_unit_pkg::*;
#(
  parameter int NUM = NUM_WATCH
) (
  // Memory operation
  input wire logic mem_valid,
  input wire logic mem_is_load,
  input wire logic [7:0] mem_thread,
  input wire logic [31:0] mem_addr,
  // Resource use
  input wire logic res_valid,
  input wire logic [7:0] res_thread,
  input wire logic [31:0] res_id,
  // Watchpoint settings
  input wire logic [31:0] dw_addr1 [NUM],
  input wire logic [31:0] dw_addr2 [NUM],
  input wire logic [31:0] dw_ctrl [NUM],
  input wire logic [31:0] rw_mask [NUM],
  input wire logic [31:0] rw_value [NUM],
  input wire logic [31:0] rw_ctrl [NUM],
  // Results
  output logic [NUM-1:0] data_hit,
  output logic [NUM-1:0] res_hit
);

  initial begin
    if (NUM < 1 || NUM > NUM_WATCH) $error("watch_match: NUM out of range");
  end

  // Range check: A is lower bound, B upper bound, so AND gives a window
  always_comb begin
    logic cond_a;
    logic cond_b;
    logic load_ok;
    logic match;
    cond_a = 1'b0;
    cond_b = 1'b0;
    load_ok = 1'b0;
    match = 1'b0;
    for (int i = 0; i < NUM; i++) begin
      cond_a = mem_addr >= dw_addr1[i]; // RULE_21
      cond_b = mem_addr <= dw_addr2[i]; // RULE_21
      load_ok = !mem_is_load || dw_ctrl[i][TRIGGER_ON_LOAD_BIT]; // RULE_17
      match = dw_ctrl[i][AND_OR_SELECT_BIT] ? (cond_a || cond_b) : (cond_a && cond_b); // RULE_16
      data_hit[i] = mem_valid && load_ok && match
                    && thread_enabled(dw_ctrl[i], mem_thread); // RULE_15
    end
  end

  always_comb begin
    logic cond_a;
    cond_a = 1'b0;
    for (int i = 0; i < NUM; i++) begin
      cond_a = (res_id & rw_mask[i]) == rw_value[i]; // RULE_22
      res_hit[i] = res_valid && thread_enabled(rw_ctrl[i], res_thread) // RULE_18 RULE_20
                   && (rw_ctrl[i][AND_OR_SELECT_BIT] ? !cond_a : cond_a); // RULE_19
    end
  end

endmodule // watch_match
`default_nettype wire
